//--- pkg/rrgk_defines.svh
// constants for the row repair guard key entry block
`ifndef RRGK_DEFINES_SVH
`define RRGK_DEFINES_SVH

// ----------------
// register byte offsets
// ----------------
`define RRGK_OFF_CTRL        12'h000
`define RRGK_OFF_STATUS      12'h004
`define RRGK_OFF_FUSE        12'h008
`define RRGK_OFF_ROW         12'h00c

// ----------------
// field positions and reset values
// ----------------
`define RRGK_CTRL_LOWDC_BIT  0
`define RRGK_CTRL_SEL_LO     4
`define RRGK_CTRL_RST        32'h0000_0000
`define RRGK_HARD_EN_BIT     13
`define RRGK_SOFT_EN_BIT     5

// ----------------
// mode register select codes {bank group bit 0, bank}
// ----------------
`define RRGK_SEL_MODE_ZERO   3'h0
`define RRGK_SEL_MODE_FOUR   3'h4

// ----------------------------------------------------------------
// guard key address fields, upper field address bits 11 down to 7, low field bits 6 down to 0
// ----------------------------------------------------------------
`define RRGK_KEY_STEP1       5'h19
`define RRGK_KEY_STEP2       5'h0f
`define RRGK_KEY_STEP3       5'h17
`define RRGK_KEY_STEP4       5'h07
`define RRGK_KEY_LOW         7'h7f
`define RRGK_KEY_STEPS       2'h3

`endif

//--- pkg/rrgk_pkg.sv
// types shared by the row repair guard key entry block
package rrgk_pkg;

    // command bus operation codes
    typedef enum logic [3:0] {
        RRGK_OP_NOP = 4'h0,
        RRGK_OP_MRS = 4'h1,
        RRGK_OP_ACT = 4'h2,
        RRGK_OP_WR  = 4'h3,
        RRGK_OP_WRA = 4'h4,
        RRGK_OP_RD  = 4'h5,
        RRGK_OP_PRE = 4'h6,
        RRGK_OP_REF = 4'h7,
        RRGK_OP_ZQ  = 4'h8,
        RRGK_OP_RFU = 4'h9
    } rrgk_op_t;

    // one decoded command from the memory controller
    typedef struct packed {
        logic        valid;
        rrgk_op_t    op;
        logic [1:0]  bank_group_select;
        logic [1:0]  bank_select;
        logic [17:0] addr;
    } rrgk_cmd_t;

    // repair entry states, gray along idle-key-armed-row-program
    typedef enum logic [2:0] {
        RRGK_ST_IDLE    = 3'b000,
        RRGK_ST_KEY     = 3'b001,
        RRGK_ST_ARMED   = 3'b011,
        RRGK_ST_ROW     = 3'b010,
        RRGK_ST_PROGRAM = 3'b110,
        RRGK_ST_ABORT   = 3'b100
    } rrgk_state_t;

    // one repair element write
    typedef struct packed {
        logic        we;
        logic        hard;
        logic [1:0]  bg;
        logic [17:0] row;
    } rrgk_fuse_wr_t;

endpackage

//--- hdl/rrgk_key_check.sv
// guard key step counter and per-step field compare
`timescale 1ns/1ns
`include "rrgk_defines.svh"
module rrgk_key_check
    import rrgk_pkg::*;
(
    input  wire logic      pclk,     // clock
    input  wire logic      presetn,  // async reset, low
    input  wire logic      run,      // key entry in progress
    input  wire logic      low_dc,   // low seven bits ignored
    input  wire rrgk_cmd_t cmd,      // command this cycle
    output logic           match,    // command is the expected step
    output logic           last      // command completes the key
);

    logic [1:0] step_reg;
    logic [1:0] step_next;
    logic [4:0] want;

    // expected upper field for the current step
    always_comb begin
        unique case (step_reg)
            2'h0: want = `RRGK_KEY_STEP1;
            2'h1: want = `RRGK_KEY_STEP2;
            2'h2: want = `RRGK_KEY_STEP3;
            2'h3: want = `RRGK_KEY_STEP4;
        endcase
    end

    always_comb begin
        match = cmd.valid && (cmd.op == RRGK_OP_MRS)
            && (cmd.bank_group_select == 2'h0)
            && (cmd.bank_select == 2'h0)
            && (cmd.addr[11:7] == want)
            && (low_dc || (cmd.addr[6:0] == `RRGK_KEY_LOW));
        last = match && (step_reg == `RRGK_KEY_STEPS);
    end

    always_comb begin
        step_next = step_reg;
        if (!run) begin
            step_next = 2'h0;
        end else if (cmd.valid) begin
            step_next = match ? step_reg + 2'h1 : 2'h0;
        end
    end

    // step register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg <= 2'h0;
        end else begin
            step_reg <= step_next;
        end
    end

endmodule

//--- hdl/rrgk_fuse_mem.sv
// repair element store, one element per bank group
`timescale 1ns/1ns
module rrgk_fuse_mem
    import rrgk_pkg::*;
(
    input  wire logic          pclk,      // clock
    input  wire logic          presetn,   // async reset, low
    input  wire rrgk_fuse_wr_t wr,        // element write
    input  wire logic [1:0]    rd_bg,     // readback bank group
    output logic [17:0]        rd_row,    // registered row readback
    output logic [3:0]         hard_used, // hard element used per bg
    output logic [3:0]         soft_used  // soft element used per bg
);

    logic [17:0] row_reg [4];
    logic [17:0] row_next [4];
    logic [3:0]  hard_reg;
    logic [3:0]  hard_next;
    logic [3:0]  soft_reg;
    logic [3:0]  soft_next;
    logic [17:0] rd_reg;

    // element update, hard bits only ever set
    always_comb begin
        hard_next = hard_reg;
        soft_next = soft_reg;
        for (int i = 0; i < 4; i++) begin
            row_next[i] = row_reg[i];
        end
        if (wr.we) begin
            row_next[wr.bg] = wr.row;
            hard_next[wr.bg] = hard_reg[wr.bg] | wr.hard;
            soft_next[wr.bg] = soft_reg[wr.bg] | !wr.hard;
        end
    end

    // storage and registered read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hard_reg <= 4'h0;
            soft_reg <= 4'h0;
            rd_reg   <= 18'h0;
            for (int i = 0; i < 4; i++) begin
                row_reg[i] <= 18'h0;
            end
        end else begin
            hard_reg <= hard_next;
            soft_reg <= soft_next;
            rd_reg   <= row_reg[rd_bg];
            for (int i = 0; i < 4; i++) begin
                row_reg[i] <= row_next[i];
            end
        end
    end

    assign rd_row    = rd_reg;
    assign hard_used = hard_reg;
    assign soft_used = soft_reg;

endmodule

//--- hdl/rrgk_top.sv
// row repair mode entry, guard key check and repair dispatch
`timescale 1ns/1ns
`include "rrgk_defines.svh"
module rrgk_top
    import rrgk_pkg::*;
(
    input  wire logic        pclk,         // clock, 250 MHz
    input  wire logic        presetn,      // async reset, low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb direction
    input  wire logic [11:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic [31:0]      prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    input  wire rrgk_cmd_t   cmd,          // controller command
    output logic             normal_cmd,   // command run as ordinary access
    output logic             key_abort,    // key entry interrupted
    output logic             repair_fire,  // repair element written
    output logic             repair_hard,  // last repair was hard
    output logic [1:0]       repair_bg,    // last repaired bank group
    output logic [17:0]      repair_row,   // last repaired row
    output logic             repair_refuse,// repair refused, bg used or soft in use for hard
    output logic [15:0]      ref_bank_en,  // banks refreshed by a ref
    output logic             ref_unsafe    // ref during plain write repair
);

    // ----------------
    // command decode
    // ----------------

    // mode register write to a given register select
    function automatic logic is_mrs(rrgk_cmd_t c, logic [2:0] sel);
        return c.valid && (c.op == RRGK_OP_MRS)
            && ({c.bank_group_select[0], c.bank_select} == sel);
    endfunction

    logic mr4_wr;
    logic hard_bit;
    logic soft_bit;
    logic is_act;
    logic is_write;
    logic is_ref;

    // decoded strobes for this cycle
    always_comb begin
        mr4_wr   = is_mrs(cmd, `RRGK_SEL_MODE_FOUR);
        hard_bit = cmd.addr[`RRGK_HARD_EN_BIT];
        soft_bit = cmd.addr[`RRGK_SOFT_EN_BIT];
        is_act   = cmd.valid && (cmd.op == RRGK_OP_ACT);
        is_write = cmd.valid
            && ((cmd.op == RRGK_OP_WR) || (cmd.op == RRGK_OP_WRA));
        is_ref   = cmd.valid && (cmd.op == RRGK_OP_REF);
    end

    // ----------------
    // registers and submodules
    // ----------------
    rrgk_state_t   state_reg, state_next;
    logic          hard_reg, hard_next;      // mode bit 13 copy
    logic          soft_reg, soft_next;      // mode bit 5 copy
    logic          wra_reg, wra_next;        // repair used autoprecharge
    logic [1:0]    bg_reg, bg_next;          // open repair bank group
    logic          ba1_reg, ba1_next;        // open repair bank bit 1
    logic [17:0]   row_reg, row_next;        // open repair row
    logic          hrep_reg, hrep_next;      // last repair kind
    logic [1:0]    rbg_reg, rbg_next;        // last repaired bg
    logic [17:0]   rrow_reg, rrow_next;      // last repaired row
    logic          norm_reg, norm_next;
    logic          abort_reg, abort_next;
    logic          fire_reg, fire_next;
    logic          refuse_reg, refuse_next;
    logic          unsafe_reg, unsafe_next;
    logic [15:0]   refen_reg, refen_next;
    logic [31:0]   ctrl_reg, ctrl_next;
    logic          key_match;
    logic          key_last;
    logic [3:0]    hard_used;
    logic [3:0]    soft_used;
    logic [17:0]   fuse_row;
    rrgk_fuse_wr_t fuse_wr;
    logic          repair_ok;
    logic [15:0]   ref_mask;

    // guard key checker, one key for both modes
    rrgk_key_check u_key (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_reg == RRGK_ST_KEY),
        .low_dc  (ctrl_reg[`RRGK_CTRL_LOWDC_BIT]),
        .cmd     (cmd),
        .match   (key_match),
        .last    (key_last)
    );

    // repair element store
    rrgk_fuse_mem u_fuse (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr        (fuse_wr),
        .rd_bg     (ctrl_reg[`RRGK_CTRL_SEL_LO +: 2]),
        .rd_row    (fuse_row),
        .hard_used (hard_used),
        .soft_used (soft_used)
    );

    // one element per bank group; hard needs soft cleared
    always_comb begin
        if (hard_reg) begin
            repair_ok = !hard_used[bg_reg] && (soft_used == 4'h0);
        end else begin
            repair_ok = !hard_used[bg_reg] && !soft_used[bg_reg];
        end
    end

    // refresh skips both banks of the repaired pair
    for (genvar b = 0; b < 16; b++) begin : g_ref
        assign ref_mask[b] = !((2'(b / 4) == bg_reg) && (1'(b / 2) == ba1_reg));
    end

    // ----------------
    // repair entry sequencer
    // ----------------
    always_comb begin
        state_next  = state_reg;
        hard_next   = hard_reg;
        soft_next   = soft_reg;
        wra_next    = wra_reg;
        bg_next     = bg_reg;
        ba1_next    = ba1_reg;
        row_next    = row_reg;
        hrep_next   = hrep_reg;
        rbg_next    = rbg_reg;
        rrow_next   = rrow_reg;
        norm_next   = 1'b0;
        abort_next  = 1'b0;
        fire_next   = 1'b0;
        refuse_next = 1'b0;
        unsafe_next = 1'b0;
        refen_next  = 16'h0;
        fuse_wr     = '0;
        if (mr4_wr) begin
            hard_next = hard_bit;
            soft_next = soft_bit;
        end
        unique case (state_reg)
            RRGK_ST_IDLE: begin
                norm_next = cmd.valid;
                if (is_ref) begin
                    refen_next = 16'hffff;
                end
                if (mr4_wr && (hard_bit || soft_bit)) begin
                    state_next = RRGK_ST_KEY;
                end
            end
            RRGK_ST_KEY: begin
                if (mr4_wr && !hard_bit && !soft_bit) begin
                    state_next = RRGK_ST_IDLE;
                    norm_next  = 1'b1;
                end else if (key_last) begin
                    state_next = RRGK_ST_ARMED;
                end else if (cmd.valid && !key_match) begin
                    state_next = RRGK_ST_ABORT;
                    abort_next = 1'b1;
                end
            end
            RRGK_ST_ARMED: begin
                if (mr4_wr && !hard_bit && !soft_bit) begin
                    state_next = RRGK_ST_IDLE;
                end else if (is_act) begin
                    // activate now names the failing row
                    state_next = RRGK_ST_ROW;
                    bg_next    = cmd.bank_group_select;
                    ba1_next   = cmd.bank_select[1];
                    row_next   = cmd.addr;
                end
            end
            RRGK_ST_ROW: begin
                if (mr4_wr && !hard_bit && !soft_bit) begin
                    state_next = RRGK_ST_IDLE;
                end else if (is_write) begin
                    state_next = RRGK_ST_PROGRAM;
                    wra_next   = (cmd.op == RRGK_OP_WRA);
                    if (repair_ok) begin
                        fuse_wr.we   = 1'b1;
                        fuse_wr.hard = hard_reg;
                        fuse_wr.bg   = bg_reg;
                        fuse_wr.row  = row_reg;
                        fire_next    = 1'b1;
                        hrep_next    = hard_reg;
                        rbg_next     = bg_reg;
                        rrow_next    = row_reg;
                    end else begin
                        refuse_next = 1'b1;
                    end
                end
            end
            RRGK_ST_PROGRAM: begin
                if (mr4_wr && !hard_bit && !soft_bit) begin
                    state_next = RRGK_ST_IDLE;
                end else if (is_ref) begin
                    if (wra_reg) begin
                        refen_next = ref_mask;
                    end else begin
                        // no refresh in plain write repair
                        unsafe_next = 1'b1;
                    end
                end
            end
            RRGK_ST_ABORT: begin
                norm_next = cmd.valid;
                if (is_ref) begin
                    refen_next = 16'hffff;
                end
                if (mr4_wr && !hard_bit && !soft_bit) begin
                    state_next = RRGK_ST_IDLE;
                end
            end
            default: begin
                state_next = RRGK_ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= RRGK_ST_IDLE;
            hard_reg   <= 1'b0;
            soft_reg   <= 1'b0;
            wra_reg    <= 1'b0;
            bg_reg     <= 2'h0;
            ba1_reg    <= 1'b0;
            row_reg    <= 18'h0;
            hrep_reg   <= 1'b0;
            rbg_reg    <= 2'h0;
            rrow_reg   <= 18'h0;
            norm_reg   <= 1'b0;
            abort_reg  <= 1'b0;
            fire_reg   <= 1'b0;
            refuse_reg <= 1'b0;
            unsafe_reg <= 1'b0;
            refen_reg  <= 16'h0;
        end else begin
            state_reg  <= state_next;
            hard_reg   <= hard_next;
            soft_reg   <= soft_next;
            wra_reg    <= wra_next;
            bg_reg     <= bg_next;
            ba1_reg    <= ba1_next;
            row_reg    <= row_next;
            hrep_reg   <= hrep_next;
            rbg_reg    <= rbg_next;
            rrow_reg   <= rrow_next;
            norm_reg   <= norm_next;
            abort_reg  <= abort_next;
            fire_reg   <= fire_next;
            refuse_reg <= refuse_next;
            unsafe_reg <= unsafe_next;
            refen_reg  <= refen_next;
        end
    end

    // ----------------
    // apb register slave, one wait state
    // ----------------
    logic        rdy_reg, rdy_next;
    logic        err_reg, err_next;
    logic [31:0] rd_reg, rd_next;
    logic        hit;
    logic [31:0] rvalue;

    // register read mux
    always_comb begin
        hit    = 1'b1;
        rvalue = 32'h0;
        unique case (paddr)
            `RRGK_OFF_CTRL:   rvalue = ctrl_reg;
            `RRGK_OFF_STATUS: rvalue = {24'h0, hrep_reg, soft_reg,
                                        hard_reg, 2'h0, state_reg};
            `RRGK_OFF_FUSE:   rvalue = {24'h0, soft_used, hard_used};
            `RRGK_OFF_ROW:    rvalue = {14'h0, fuse_row};
            default:          hit = 1'b0;
        endcase
    end

    // access phase answered on the second enable cycle
    always_comb begin
        rdy_next  = 1'b0;
        err_next  = 1'b0;
        rd_next   = rd_reg;
        ctrl_next = ctrl_reg;
        if (psel && penable && !rdy_reg) begin
            rdy_next = 1'b1;
            err_next = !hit;
            rd_next  = (pwrite || !hit) ? 32'h0 : rvalue;
            if (pwrite && (paddr == `RRGK_OFF_CTRL)) begin
                ctrl_next = {26'h0, pwdata[5:4], 3'h0, pwdata[0]};
            end
        end
    end

    // bus registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_reg  <= 1'b0;
            err_reg  <= 1'b0;
            rd_reg   <= 32'h0;
            ctrl_reg <= `RRGK_CTRL_RST;
        end else begin
            rdy_reg  <= rdy_next;
            err_reg  <= err_next;
            rd_reg   <= rd_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ----------------
    // outputs
    // ----------------
    assign prdata        = rd_reg;
    assign pready        = rdy_reg;
    assign pslverr       = err_reg;
    assign normal_cmd    = norm_reg;
    assign key_abort     = abort_reg;
    assign repair_fire   = fire_reg;
    assign repair_hard   = hrep_reg;
    assign repair_bg     = rbg_reg;
    assign repair_row    = rrow_reg;
    assign repair_refuse = refuse_reg;
    assign ref_bank_en   = refen_reg;
    assign ref_unsafe    = unsafe_reg;

endmodule

//--- bench/rrgk_properties.sv
// assertions on the row repair guard key entry ports
`timescale 1ns/1ns
`include "rrgk_defines.svh"
module rrgk_properties
    import rrgk_pkg::*;
(
    input wire logic      pclk,         // clock
    input wire logic      presetn,      // async reset, low
    input wire logic      psel,         // apb select
    input wire logic      penable,      // apb enable
    input wire logic      pready,       // apb ready
    input wire rrgk_cmd_t cmd,          // controller command
    input wire logic      normal_cmd,   // ordinary access
    input wire logic      key_abort,    // key interrupted
    input wire logic      repair_fire,  // element written
    input wire logic      repair_hard,  // kind of repair
    input wire logic      repair_refuse // repair refused
);
    // ----------------
    // command decode
    // ----------------
    wire mrs = cmd.valid && cmd.op == RRGK_OP_MRS && cmd.bank_select == 2'h0;
    wire mr0 = mrs && cmd.bank_group_select == 2'h0
        && cmd.addr[6:0] == `RRGK_KEY_LOW;
    wire mr4 = mrs && cmd.bank_group_select[0];
    wire clr = mr4 && !cmd.addr[13] && !cmd.addr[5];
    wire k1  = mr0 && cmd.addr[11:7] == `RRGK_KEY_STEP1;
    wire k2  = mr0 && cmd.addr[11:7] == `RRGK_KEY_STEP2;
    wire k3  = mr0 && cmd.addr[11:7] == `RRGK_KEY_STEP3;
    wire k4  = mr0 && cmd.addr[11:7] == `RRGK_KEY_STEP4;
    wire act = cmd.valid && cmd.op == RRGK_OP_ACT;
    wire wrc = cmd.valid && (cmd.op == RRGK_OP_WR || cmd.op == RRGK_OP_WRA);
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_key;
        k1 ##1 k2 ##1 k3 ##1 k4;
    endsequence
    sequence s_use;
        act ##1 wrc;
    endsequence
    property p_hard_fire;
        clr ##1 (mr4 && cmd.addr[13]) ##1 s_key ##1 s_use
            |=> (repair_fire && repair_hard) != repair_refuse;
    endproperty
    a_hard_fire: assert property (p_hard_fire)
        else $error("hard repair not dispatched");
    property p_soft_fire;
        clr ##1 (mr4 && cmd.addr[5] && !cmd.addr[13]) ##1 s_key ##1 s_use
            |=> (repair_fire && !repair_hard) != repair_refuse;
    endproperty
    a_soft_fire: assert property (p_soft_fire)
        else $error("soft repair not dispatched");
    property p_abort_first;
        clr ##1 (mr4 && !clr) ##1 (cmd.valid && !k1 && !clr) |=> key_abort;
    endproperty
    a_abort_first: assert property (p_abort_first)
        else $error("bad first key step not aborted");
    property p_abort_mid;
        clr ##1 (mr4 && !clr) ##1 k1 ##1 (cmd.valid && !k2 && !clr)
            |=> key_abort;
    endproperty
    a_abort_mid: assert property (p_abort_mid)
        else $error("out of order key not aborted");
    property p_after;
        key_abort && (act || wrc) |=> normal_cmd && !repair_fire;
    endproperty
    a_after: assert property (p_after)
        else $error("access after abort not ordinary");
    property p_clr;
        clr |=> !key_abort && !repair_fire && !repair_refuse;
    endproperty
    a_clr: assert property (p_clr)
        else $error("enable clear caused an event");
    property p_abort_once;
        key_abort |=> !key_abort;
    endproperty
    a_abort_once: assert property (p_abort_once)
        else $error("abort repeated");
    property p_apb;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb: assert property (p_apb)
        else $error("apb answer late");
endmodule

//--- bench/rrgk_ctrl_model.sv
// memory controller model driving the command bus
`timescale 1ns/1ns
`include "rrgk_defines.svh"
module rrgk_ctrl_model
    import rrgk_pkg::*;
(
    input  wire logic pclk, // clock
    output rrgk_cmd_t cmd   // command bus
);
    logic [4:0] step [4];
    initial begin
        cmd = '0;
        step = '{`RRGK_KEY_STEP1, `RRGK_KEY_STEP2,
                 `RRGK_KEY_STEP3, `RRGK_KEY_STEP4};
    end
    // one command, taken at the next edge
    task automatic issue(input rrgk_op_t op, input logic [3:0] bb,
                         input logic [17:0] a);
        @(posedge pclk);
        cmd <= {1'b1, op, bb, a};
    endtask
    // deselect, fields inverted
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge pclk);
            cmd <= {1'b0, ~cmd[25:0]};
        end
    endtask
    task automatic enter(input logic h, input logic s);
        issue(RRGK_OP_MRS, 4'h4, 18'h0);
        issue(RRGK_OP_MRS, 4'h4, {4'h0, h, 7'h0, s, 5'h0});
    endtask
    // key right after enable, spaced, broken on demand
    task automatic key(input int bad, input rrgk_op_t bop,
                       input logic [4:0] hi, input int g);
        for (int i = 0; i < 4; i++) begin
            if (i > 0)
                idle(g);
            if (i == bad) begin
                issue(bop, 4'h0, 18'h3ffff);
                return;
            end
            issue(RRGK_OP_MRS, 4'h0, {1'b0, hi, step[i], `RRGK_KEY_LOW});
        end
    endtask
endmodule

//--- bench/row_repair_guard_key_entry_bench.sv
// self-checking bench for the row repair guard key entry block
`timescale 1ns/1ns
`include "rrgk_defines.svh"
module row_repair_guard_key_entry_bench
    import rrgk_pkg::*;
;
    typedef struct packed {
        logic [3:0]  f;   // abort, fire, refuse, unsafe
        logic [15:0] rb;  // refreshed banks, 0 unchecked
        logic        h;
        logic [1:0]  bg;
        logic [17:0] row;
    } rrgk_exp_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        normal_cmd, key_abort, repair_fire, repair_hard;
    logic        repair_refuse, ref_unsafe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  repair_bg;
    logic [17:0] repair_row, rows [4];
    logic [15:0] ref_bank_en;
    rrgk_cmd_t   cmd;
    rrgk_exp_t   eq [$];
    logic [32:0] aq [$];
    logic [4:0]  tb [6] = '{5'h1b, 5'h1d, 5'h18, 5'h07, 5'h14, 5'h12};
    integer      seed, failures = 0, cmp_count = 0;
    rrgk_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cmd, .normal_cmd, .key_abort,
        .repair_fire, .repair_hard, .repair_bg, .repair_row, .repair_refuse,
        .ref_bank_en, .ref_unsafe);
    rrgk_ctrl_model u_ctrl (.pclk, .cmd);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ----------------
    // compare and report
    // ----------------
    task automatic bad(input string m);
        failures++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic cmp_apb(input logic [32:0] e);
        cmp_count++;
        if ({pslverr, prdata} !== e) bad("apb answer");
    endtask
    task automatic cmp_ev(input rrgk_exp_t e);
        cmp_count++;
        if ({key_abort, repair_fire, repair_refuse, ref_unsafe} !== e.f)
            bad("event flags");
        if (e.rb != 0 && ref_bank_en !== e.rb) bad("refresh banks");
        if (e.f[2] && {repair_hard, repair_bg, repair_row}
            !== {e.h, e.bg, e.row}) bad("repair element");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // outputs checked against the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (aq.size() == 0) bad("stray ready");
            else cmp_apb(aq.pop_front());
        end
        if ({key_abort, repair_fire, repair_refuse, ref_unsafe} !== 4'h0
            || ref_bank_en !== 16'h0) begin
            if (eq.size() == 0) bad("unexpected event");
            else cmp_ev(eq.pop_front());
        end
    end
    // ----------------
    // drivers and scenarios
    // ----------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        aq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // {hard, bank group, autoprecharge, accepted}
    task automatic repair(input logic [4:0] t, input int g);
        logic [17:0] row;
        logic [1:0]  ba;
        row = 18'($random(seed));
        ba = 2'($random(seed));
        u_ctrl.enter(t[4], !t[4]);
        u_ctrl.key(4, RRGK_OP_NOP, 5'($random(seed)), g);
        u_ctrl.issue(RRGK_OP_ACT, {t[3:2], ba}, row);
        eq.push_back({1'b0, t[0], !t[0], 1'b0, 16'h0, t[4], t[3:2], row});
        if (t[0]) rows[t[3:2]] = row;
        u_ctrl.issue(t[1] ? RRGK_OP_WRA : RRGK_OP_WR, {t[3:2], ba}, row);
        if (t[4] && t[0]) begin
            eq.push_back({3'h0, !t[1], t[1] ? 16'hffff
                & ~(16'h3 << {t[3:2], ba[1], 1'b0}) : 16'h0, 21'h0});
            u_ctrl.issue(RRGK_OP_REF, 4'(seed), 18'h0);
        end
        u_ctrl.idle(2);
    endtask
    initial begin
        seed = 32'h3e7bb54d;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `RRGK_OFF_CTRL, 32'h0, 33'h0);
        apb(1'b1, `RRGK_OFF_CTRL, 32'hffffffff, 33'h0);
        apb(1'b0, `RRGK_OFF_CTRL, 32'h0, 33'h31);
        apb(1'b1, `RRGK_OFF_CTRL, 32'h0, 33'h0);
        apb(1'b0, 12'h010, 32'h0, 33'h100000000);
        $display("test registers done");
        // each command op once, interrupting the key at step i mod 4
        for (int i = 0; i < 10; i++) begin
            u_ctrl.enter(i[0], 1'b1);
            eq.push_back({4'h8, 16'h0, 21'h0});
            u_ctrl.key(i % 4, rrgk_op_t'(i), 5'($random(seed)), (i >> 1) & 1);
            u_ctrl.issue(RRGK_OP_ACT, 4'h9, 18'($random(seed)));
            u_ctrl.issue(RRGK_OP_WR, 4'h9, 18'h0);
            u_ctrl.idle(1);
        end
        $display("test interruptions done");
        // hard and soft elements per bank group
        for (int i = 0; i < 6; i++) repair(tb[i], i & 1);
        u_ctrl.enter(1'b0, 1'b0);
        u_ctrl.idle(2);
        apb(1'b0, `RRGK_OFF_FUSE, 32'h0, 33'h2c);
        apb(1'b1, `RRGK_OFF_CTRL, 32'h20, 33'h0);
        apb(1'b0, `RRGK_OFF_ROW, 32'h0, 33'(rows[2]));
        apb(1'b0, `RRGK_OFF_STATUS, 32'h0, 33'h0);
        $display("test repairs done");
        repeat (4) @(posedge pclk);
        if (eq.size() + aq.size() != 0) bad("results missing");
        wrap_up();
    end
    initial begin
        #20000;
        bad("timeout");
        wrap_up();
    end
endmodule
bind rrgk_top rrgk_properties u_props (.pclk, .presetn, .psel, .penable,
    .pready, .cmd, .normal_cmd, .key_abort, .repair_fire, .repair_hard,
    .repair_refuse);
